/* rtl/sxpd_pkg.sv */
package sxpd_pkg;
    // Opcode patterns
    localparam logic [7:0] SXPD_OP_SEG_COPY   = 8'h8C;
    localparam logic [7:0] SXPD_OP_GRP_FF     = 8'hFF;
    localparam logic [7:0] SXPD_OP_POP_MEM    = 8'h8F;
    localparam logic [7:0] SXPD_OP_STORE_ALL  = 8'h60;
    localparam logic [7:0] SXPD_OP_LOAD_ALL   = 8'h61;
    localparam logic [4:0] SXPD_OP5_PUSH_REG  = 5'h0A;
    localparam logic [4:0] SXPD_OP5_POP_REG   = 5'h0B;
    localparam logic [4:0] SXPD_OP5_SWAP_ACC  = 5'h12;
    localparam logic [6:0] SXPD_OP7_SWAP_RM   = 7'h43;
    localparam logic [6:0] SXPD_OP7_IN_FIXED  = 7'h72;
    localparam logic [5:0] SXPD_OP6_PUSH_IMM  = 6'h1A;
    localparam logic [2:0] SXPD_SEG_HI        = 3'h0;
    localparam logic [2:0] SXPD_SEG_PUSH_LO   = 3'h6;
    localparam logic [2:0] SXPD_SEG_POP_LO    = 3'h7;
    localparam logic [1:0] SXPD_SEG_NO_POP    = 2'h1;
    localparam logic [2:0] SXPD_MID_PUSH_MEM  = 3'h6;
    localparam logic [2:0] SXPD_MID_POP_MEM   = 3'h0;
    localparam logic [1:0] SXPD_MOD_REG       = 2'h3;
    // Field positions
    localparam int SXPD_W_BIT = 0;
    localparam int SXPD_S_BIT = 1;
    localparam int SXPD_SIGN_BIT = 7;
    // Cycle counts per form
    localparam logic [5:0] SXPD_CYC_SEG_REG   = 6'h02;
    localparam logic [5:0] SXPD_CYC_SEG_MEM   = 6'h0B;
    localparam logic [5:0] SXPD_CYC_PUSH_MEM  = 6'h10;
    localparam logic [5:0] SXPD_CYC_PUSH_REG  = 6'h0A;
    localparam logic [5:0] SXPD_CYC_PUSH_SEG  = 6'h09;
    localparam logic [5:0] SXPD_CYC_PUSH_IMM  = 6'h0A;
    localparam logic [5:0] SXPD_CYC_STORE_ALL = 6'h24;
    localparam logic [5:0] SXPD_CYC_POP_MEM   = 6'h14;
    localparam logic [5:0] SXPD_CYC_POP_REG   = 6'h0A;
    localparam logic [5:0] SXPD_CYC_POP_SEG   = 6'h08;
    localparam logic [5:0] SXPD_CYC_LOAD_ALL  = 6'h33;
    localparam logic [5:0] SXPD_CYC_SWAP_REG  = 6'h04;
    localparam logic [5:0] SXPD_CYC_SWAP_MEM  = 6'h11;
    localparam logic [5:0] SXPD_CYC_SWAP_ACC  = 6'h03;
    localparam logic [5:0] SXPD_CYC_IN_FIXED  = 6'h0A;
    // Operation codes reported on completion
    typedef enum logic [3:0] {
        SXPD_NONE      = 4'h0,
        SXPD_SEG_COPY  = 4'h1,
        SXPD_PUSH_MEM  = 4'h2,
        SXPD_PUSH_REG  = 4'h3,
        SXPD_PUSH_SEG  = 4'h4,
        SXPD_PUSH_IMM  = 4'h5,
        SXPD_STORE_ALL = 4'h6,
        SXPD_POP_MEM   = 4'h7,
        SXPD_POP_REG   = 4'h8,
        SXPD_POP_SEG   = 4'h9,
        SXPD_LOAD_ALL  = 4'hA,
        SXPD_SWAP_RM   = 4'hB,
        SXPD_SWAP_ACC  = 4'hC,
        SXPD_IN_FIXED  = 4'hD,
        SXPD_ILLEGAL   = 4'hF
    } sxpd_op_type;
    // Decoder states
    typedef enum logic [4:0] {
        SXPD_ST_OPC  = 5'b00001,
        SXPD_ST_MODRM = 5'b00010,
        SXPD_ST_IMM0 = 5'b00100,
        SXPD_ST_IMM1 = 5'b01000,
        SXPD_ST_EXEC = 5'b10000
    } sxpd_state_type;
endpackage

/* rtl/sxpd_byte_if.sv */
`timescale 1ns/1ps
// Byte stream from the fetch queue into the classifier and sequencer
interface sxpd_byte_if;
    logic [7:0] opcode;
    logic [7:0] modrm;
    sxpd_pkg::sxpd_op_type op;
    logic [5:0] cycles;
    logic       need_modrm;
    logic       need_imm;
    modport cls (input opcode, input modrm, output op, output cycles, output need_modrm, output need_imm);
    modport seq (output opcode, output modrm, input op, input cycles, input need_modrm, input need_imm);
endinterface

/* rtl/sxpd_classify.sv */
`timescale 1ns/1ps
// Pure decode of opcode plus addressing byte into operation and cycle count
module sxpd_classify
    import sxpd_pkg::*;
(
    sxpd_byte_if.cls bus    // Opcode and addressing byte in, decode out
);
    logic       mem_form;
    logic [2:0] mid;
    assign mem_form = (bus.modrm[7:6] != SXPD_MOD_REG);
    assign mid      = bus.modrm[5:3];

    // Opcode classification; memory forms resolved once the addressing byte is known
    always_comb begin
        bus.op         = SXPD_ILLEGAL;
        bus.cycles     = 6'h01;
        bus.need_modrm = 1'b0;
        bus.need_imm   = 1'b0;
        if (bus.opcode == SXPD_OP_SEG_COPY) begin
            bus.op         = SXPD_SEG_COPY;
            bus.need_modrm = 1'b1;
            bus.cycles     = mem_form ? SXPD_CYC_SEG_MEM : SXPD_CYC_SEG_REG;
        end else if (bus.opcode == SXPD_OP_GRP_FF) begin
            bus.need_modrm = 1'b1;
            if (mid == SXPD_MID_PUSH_MEM) begin
                bus.op     = SXPD_PUSH_MEM;
                bus.cycles = SXPD_CYC_PUSH_MEM;
            end
        end else if (bus.opcode == SXPD_OP_POP_MEM) begin
            bus.need_modrm = 1'b1;
            if (mid == SXPD_MID_POP_MEM) begin
                bus.op     = SXPD_POP_MEM;
                bus.cycles = SXPD_CYC_POP_MEM;
            end
        end else if (bus.opcode[7:3] == SXPD_OP5_PUSH_REG) begin
            bus.op     = SXPD_PUSH_REG;
            bus.cycles = SXPD_CYC_PUSH_REG;
        end else if (bus.opcode[7:3] == SXPD_OP5_POP_REG) begin
            bus.op     = SXPD_POP_REG;
            bus.cycles = SXPD_CYC_POP_REG;
        end else if (bus.opcode[7:5] == SXPD_SEG_HI && bus.opcode[2:0] == SXPD_SEG_PUSH_LO) begin
            bus.op     = SXPD_PUSH_SEG;
            bus.cycles = SXPD_CYC_PUSH_SEG;
        end else if (bus.opcode[7:5] == SXPD_SEG_HI && bus.opcode[2:0] == SXPD_SEG_POP_LO
                     && bus.opcode[4:3] != SXPD_SEG_NO_POP) begin
            bus.op     = SXPD_POP_SEG;
            bus.cycles = SXPD_CYC_POP_SEG;
        end else if (bus.opcode[7:2] == SXPD_OP6_PUSH_IMM && !bus.opcode[SXPD_W_BIT]) begin
            bus.op       = SXPD_PUSH_IMM;
            bus.need_imm = 1'b1;
            bus.cycles   = SXPD_CYC_PUSH_IMM;
        end else if (bus.opcode == SXPD_OP_STORE_ALL) begin
            bus.op     = SXPD_STORE_ALL;
            bus.cycles = SXPD_CYC_STORE_ALL;
        end else if (bus.opcode == SXPD_OP_LOAD_ALL) begin
            bus.op     = SXPD_LOAD_ALL;
            bus.cycles = SXPD_CYC_LOAD_ALL;
        end else if (bus.opcode[7:1] == SXPD_OP7_SWAP_RM) begin
            bus.op         = SXPD_SWAP_RM;
            bus.need_modrm = 1'b1;
            bus.cycles     = mem_form ? SXPD_CYC_SWAP_MEM : SXPD_CYC_SWAP_REG;
        end else if (bus.opcode[7:3] == SXPD_OP5_SWAP_ACC) begin
            bus.op     = SXPD_SWAP_ACC;
            bus.cycles = SXPD_CYC_SWAP_ACC;
        end else if (bus.opcode[7:1] == SXPD_OP7_IN_FIXED) begin
            bus.op       = SXPD_IN_FIXED;
            bus.need_imm = 1'b1;
            bus.cycles   = SXPD_CYC_IN_FIXED;
        end
    end
endmodule

/* rtl/sxpd_decode.sv */
`timescale 1ns/1ps
// Contract
// - 8C plus addressing byte copies a segment register; 2 clocks register, 11 memory.
// - FF with middle field 110 stores memory operand on stack in 16 clocks.
// - 01010rrr stores general register on stack in 10 clocks.
// - 000ss110 stores segment register on stack in 9 clocks.
// - Immediate store fetches one byte, second only if sign bit zero; 10 clocks.
// - 60 stores all general registers on stack in 36 clocks.
// - 8F with middle field 000 loads memory operand from stack in 20 clocks.
// - 01011rrr loads general register from stack in 10 clocks.
// - 000ss111 loads segment register in 8 clocks; selector 01 is not this operation.
// - 61 reloads all general registers from stack in 51 clocks.
// - 1000011w with addressing byte swaps operands; 4 clocks register, 17 memory.
// - 10010rrr swaps accumulator with register in 3 clocks.
// - 1110010w with port byte reads fixed port into accumulator in 10 clocks.
module sxpd_decode
    import sxpd_pkg::*;
(
    input  wire logic        core_clk_i,  // Core clock, 40 MHz
    input  wire logic        reset_i,     // Asynchronous reset, active high
    input  wire logic [7:0]  q_byte_i,    // Byte from the fetch queue
    input  wire logic        q_valid_i,   // Queue byte present
    output logic             q_take_o,    // Byte consumed in the previous cycle
    output logic             busy_o,      // Instruction in progress
    output logic             done_o,      // One-cycle completion pulse
    output sxpd_op_type      op_o,        // Operation of finished instruction
    output logic             word_o,      // Word width when set
    output logic [2:0]       reg_o,       // Register or segment selector
    output logic [7:0]       modrm_o,     // Addressing byte
    output logic [15:0]      imm_o,       // Immediate or port number
    output logic [5:0]       cycles_o     // Clock count of finished instruction
);
    sxpd_byte_if    bus ();
    sxpd_state_type state_q;
    logic [7:0]     opc_q;
    logic [7:0]     modrm_q;
    logic [15:0]    imm_q;
    logic [5:0]     left_q;
    logic [5:0]     total_q;
    logic           two_imm;
    logic           accept;

    sxpd_classify u_cls (
        .bus (bus)
    );

    // In the opcode state the live byte is decoded so one-byte forms start at once
    assign bus.opcode = (state_q == SXPD_ST_OPC) ? q_byte_i : opc_q;
    assign bus.modrm  = (state_q == SXPD_ST_MODRM) ? q_byte_i : modrm_q;
    // Immediate store takes a second byte only with sign bit clear; port form always one
    assign two_imm = (bus.op == SXPD_PUSH_IMM) && !opc_q[SXPD_S_BIT];
    assign accept  = q_valid_i && (state_q != SXPD_ST_EXEC);

    // Fetch sequencer; the execute count starts one cycle after the last byte is taken
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= SXPD_ST_OPC;
            opc_q   <= 8'h00;
            modrm_q <= 8'h00;
            imm_q   <= 16'h0000;
            left_q  <= 6'h00;
            total_q <= 6'h00;
        end else begin
            unique case (state_q)
                SXPD_ST_OPC: begin
                    if (q_valid_i) begin
                        opc_q <= q_byte_i;
                        if (bus.need_modrm) begin
                            state_q <= SXPD_ST_MODRM;
                        end else if (bus.need_imm) begin
                            state_q <= SXPD_ST_IMM0;
                        end else begin
                            state_q <= SXPD_ST_EXEC;
                            left_q  <= bus.cycles;
                            total_q <= bus.cycles;
                        end
                    end
                end
                SXPD_ST_MODRM: begin
                    if (q_valid_i) begin
                        modrm_q <= q_byte_i;
                        state_q <= SXPD_ST_EXEC;
                        left_q  <= bus.cycles;
                        total_q <= bus.cycles;
                    end
                end
                SXPD_ST_IMM0: begin
                    if (q_valid_i) begin
                        // Single byte sign-extends for immediates, port number zero-extends
                        if (bus.op == SXPD_PUSH_IMM) begin
                            imm_q <= {{8{q_byte_i[SXPD_SIGN_BIT]}}, q_byte_i};
                        end else begin
                            imm_q <= {8'h00, q_byte_i};
                        end
                        if (two_imm) begin
                            state_q <= SXPD_ST_IMM1;
                        end else begin
                            state_q <= SXPD_ST_EXEC;
                            left_q  <= bus.cycles;
                            total_q <= bus.cycles;
                        end
                    end
                end
                SXPD_ST_IMM1: begin
                    if (q_valid_i) begin
                        imm_q[15:8] <= q_byte_i;
                        state_q     <= SXPD_ST_EXEC;
                        left_q      <= bus.cycles;
                        total_q     <= bus.cycles;
                    end
                end
                SXPD_ST_EXEC: begin
                    left_q <= left_q - 6'h01;
                    if (left_q == 6'h01) begin
                        state_q <= SXPD_ST_OPC;
                    end
                end
                default: begin
                    state_q <= SXPD_ST_OPC;
                end
            endcase
        end
    end

    // Registered handshake and result outputs
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            q_take_o <= 1'b0;
            busy_o   <= 1'b0;
            done_o   <= 1'b0;
            op_o     <= SXPD_NONE;
            word_o   <= 1'b0;
            reg_o    <= 3'h0;
            modrm_o  <= 8'h00;
            imm_o    <= 16'h0000;
            cycles_o <= 6'h00;
        end else begin
            q_take_o <= accept;
            busy_o   <= (state_q != SXPD_ST_OPC) || q_valid_i;
            done_o   <= (state_q == SXPD_ST_EXEC) && (left_q == 6'h01);
            if ((state_q == SXPD_ST_EXEC) && (left_q == 6'h01)) begin
                op_o     <= bus.op;
                // Immediate store always pushes a word; other forms follow the width bit
                word_o   <= (bus.op == SXPD_PUSH_IMM) ? 1'b1 : opc_q[SXPD_W_BIT];
                reg_o    <= (bus.op == SXPD_PUSH_SEG || bus.op == SXPD_POP_SEG) ?
                            {1'b0, opc_q[4:3]} : opc_q[2:0];
                modrm_o  <= modrm_q;
                imm_o    <= imm_q;
                cycles_o <= total_q;
            end
        end
    end

    // Helper: cycles spent in execute for the current instruction
    logic [5:0] spent_q;
    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            spent_q <= 6'h00;
        end else if (state_q == SXPD_ST_EXEC) begin
            spent_q <= spent_q + 6'h01;
        end else begin
            spent_q <= 6'h00;
        end
    end

    sequence s_exec_end;
        (state_q == SXPD_ST_EXEC) && (left_q == 6'h01);
    endsequence

    exec_length_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_exec_end |-> (spent_q + 6'h01 == total_q))
        else $error("execute length differs from decoded count");
    done_pulse_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        s_exec_end |=> done_o ##1 !done_o)
        else $error("completion pulse wrong");
    store_all_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && op_o == SXPD_STORE_ALL |-> cycles_o == SXPD_CYC_STORE_ALL)
        else $error("store all count wrong");
    load_all_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && op_o == SXPD_LOAD_ALL |-> cycles_o == SXPD_CYC_LOAD_ALL)
        else $error("load all count wrong");
    swap_acc_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && op_o == SXPD_SWAP_ACC |-> cycles_o == SXPD_CYC_SWAP_ACC)
        else $error("swap count wrong");
    seg_pop_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && op_o == SXPD_POP_SEG |-> reg_o[1:0] != SXPD_SEG_NO_POP)
        else $error("selector 01 decoded as segment load");
    imm_sext_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_q == SXPD_ST_IMM0) && q_valid_i && !two_imm && bus.op == SXPD_PUSH_IMM
        |=> imm_q[15:8] == {8{imm_q[SXPD_SIGN_BIT]}})
        else $error("immediate not sign-extended");
    imm_two_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        (state_q == SXPD_ST_IMM0) && q_valid_i && two_imm |=> state_q == SXPD_ST_IMM1)
        else $error("second immediate byte skipped");
    swap_mem_a: assert property (@(posedge core_clk_i) disable iff (reset_i)
        done_o && op_o == SXPD_SWAP_RM |->
        cycles_o == ((modrm_o[7:6] == SXPD_MOD_REG) ? SXPD_CYC_SWAP_REG : SXPD_CYC_SWAP_MEM))
        else $error("swap form count wrong");
endmodule

/* verification/sxpd_fetch_model.sv */
`timescale 1ns/1ps
// Fetch queue stand-in: offers one byte per slot and retries it until the decoder takes it
module sxpd_fetch_model (
    input  wire logic       clk_i,     // Core clock
    input  wire logic       reset_i,   // Active high reset
    input  wire logic       q_take_i,  // Take echo from the decoder
    output logic [7:0]      q_byte_o,  // Byte offered
    output logic            q_valid_o  // Byte present
);
    logic [7:0] byte_q[$];
    int         gap_q[$];

    // Queue one byte with an idle gap in front of it
    function automatic void push(logic [7:0] b, int g);
        byte_q.push_back(b);
        gap_q.push_back(g);
    endfunction

    // The echo lags by a cycle, so the byte is dropped before it is judged;
    // idle data toggles so a stale byte can never pass for a fresh one
    initial begin
        q_valid_o = 1'b0;
        q_byte_o  = 8'h5A;
        wait (reset_i === 1'b0);
        forever begin
            @(posedge clk_i);
            if (byte_q.size() == 0) begin
                q_byte_o <= ~q_byte_o;
            end else begin
                repeat (gap_q[0]) begin
                    q_byte_o <= ~q_byte_o;
                    @(posedge clk_i);
                end
                q_byte_o  <= byte_q[0];
                q_valid_o <= 1'b1;
                @(posedge clk_i);
                q_valid_o <= 1'b0;
                q_byte_o  <= ~byte_q[0];
                @(posedge clk_i);
                if (q_take_i === 1'b1) begin
                    void'(byte_q.pop_front());
                    void'(gap_q.pop_front());
                end
            end
        end
    end
endmodule

/* verification/stack_exchange_port_decode_tb.sv */
`timescale 1ns/1ps
// Self-checking bench for the stack, swap and fixed-port decoder
module stack_exchange_port_decode_tb
    import sxpd_pkg::*;
;
    typedef struct {
        sxpd_op_type op;
        logic [5:0]  cyc;
        logic        w;
        logic [2:0]  r;
        logic [15:0] imm;
        logic [7:0]  m;
        bit          cf;   // Width and register compared
        bit          ci;   // Immediate compared
        bit          cm;   // Addressing byte compared
        int          len;
    } sxpd_exp_type;

    logic        core_clk_i;
    logic        reset_i;
    logic [7:0]  q_byte_i;
    logic        q_valid_i;
    logic        q_take_o;
    logic        busy_o;
    logic        done_o;
    sxpd_op_type op_o;
    logic        word_o;
    logic [2:0]  reg_o;
    logic [7:0]  modrm_o;
    logic [15:0] imm_o;
    logic [5:0]  cycles_o;
    sxpd_exp_type exp_q[$];
    int          n_mismatch = 0;
    int          tests_run = 0;
    int          since_take = 0;
    int          cyc_cnt = 0;
    logic [31:0] rng_q = 32'h0580;
    logic [7:0]  forms [16] = '{8'h8C, 8'hFF, 8'h50, 8'h06, 8'h6A, 8'h68, 8'h60, 8'h8F,
                                8'h58, 8'h07, 8'h61, 8'h86, 8'h87, 8'h90, 8'hE4, 8'hE5};

    sxpd_decode u_dut (.core_clk_i(core_clk_i), .reset_i(reset_i), .q_byte_i(q_byte_i),
        .q_valid_i(q_valid_i), .q_take_o(q_take_o), .busy_o(busy_o), .done_o(done_o), .op_o(op_o),
        .word_o(word_o), .reg_o(reg_o), .modrm_o(modrm_o), .imm_o(imm_o), .cycles_o(cycles_o));

    sxpd_fetch_model u_fq (.clk_i(core_clk_i), .reset_i(reset_i), .q_take_i(q_take_o),
        .q_byte_o(q_byte_i), .q_valid_o(q_valid_i));

    // Clock, 25 ns period
    initial begin
        core_clk_i = 1'b0;
        forever #12.5 core_clk_i = ~core_clk_i;
    end

    function automatic logic [31:0] rnd();
        rng_q = rng_q ^ (rng_q << 13);
        rng_q = rng_q ^ (rng_q >> 17);
        rng_q = rng_q ^ (rng_q << 5);
        return rng_q;
    endfunction

    function automatic sxpd_exp_type mk(sxpd_op_type op, logic [5:0] cyc, int len, bit cm, logic [7:0] o,
                                        logic [7:0] b1);
        mk = '{op, cyc, o[0], o[2:0], {8'h00, b1}, b1, 1'b1, 1'b0, cm, len};
    endfunction

    // Reference decode written from the opcode table, independent of the design
    function automatic sxpd_exp_type ref_dec(logic [7:0] o, logic [7:0] b1, logic [7:0] b2);
        sxpd_exp_type e;
        logic         mr;
        mr = (b1[7:6] == 2'b11);
        e = mk(SXPD_ILLEGAL, 6'd1, (o == 8'hFF || o == 8'h8F) ? 2 : 1, 1'b0, o, b1);
        if (o == 8'h8C) e = mk(SXPD_SEG_COPY, mr ? 6'd2 : 6'd11, 2, 1'b1, o, b1);
        else if (o == 8'hFF && b1[5:3] == 3'b110) e = mk(SXPD_PUSH_MEM, 6'd16, 2, 1'b1, o, b1);
        else if (o[7:3] == 5'b01010) e = mk(SXPD_PUSH_REG, 6'd10, 1, 1'b0, o, b1);
        else if (o[7:5] == 3'b000 && o[2:0] == 3'b110) e = mk(SXPD_PUSH_SEG, 6'd9, 1, 1'b0, o, b1);
        else if (o[7:2] == 6'b011010 && !o[0]) e = mk(SXPD_PUSH_IMM, 6'd10, o[1] ? 2 : 3, 1'b0, o, b1);
        else if (o == 8'h60) e = mk(SXPD_STORE_ALL, 6'd36, 1, 1'b0, o, b1);
        else if (o == 8'h8F && b1[5:3] == 3'b000) e = mk(SXPD_POP_MEM, 6'd20, 2, 1'b1, o, b1);
        else if (o[7:3] == 5'b01011) e = mk(SXPD_POP_REG, 6'd10, 1, 1'b0, o, b1);
        else if (o[7:5] == 3'b000 && o[2:0] == 3'b111 && o[4:3] != 2'b01) e = mk(SXPD_POP_SEG, 6'd8, 1, 1'b0, o, b1);
        else if (o == 8'h61) e = mk(SXPD_LOAD_ALL, 6'd51, 1, 1'b0, o, b1);
        else if (o[7:1] == 7'b1000011) e = mk(SXPD_SWAP_RM, mr ? 6'd4 : 6'd17, 2, 1'b1, o, b1);
        else if (o[7:3] == 5'b10010) e = mk(SXPD_SWAP_ACC, 6'd3, 1, 1'b0, o, b1);
        else if (o[7:1] == 7'b1110010) e = mk(SXPD_IN_FIXED, 6'd10, 2, 1'b0, o, b1);
        if (e.op == SXPD_PUSH_SEG || e.op == SXPD_POP_SEG) e.r = {1'b0, o[4:3]};
        if (e.op == SXPD_PUSH_IMM) begin
            e.w   = 1'b1;
            e.imm = o[1] ? {{8{b1[7]}}, b1} : {b2, b1};
        end
        e.ci = (e.op == SXPD_PUSH_IMM || e.op == SXPD_IN_FIXED);
        e.cf = (e.op != SXPD_ILLEGAL);
        return e;
    endfunction

    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Note the expectation, then hand the whole instruction to the queue model
    task automatic send(logic [7:0] o, logic [7:0] b1, logic [7:0] b2, int gap);
        sxpd_exp_type e;
        e = ref_dec(o, b1, b2);
        exp_q.push_back(e);
        u_fq.push(o, gap);
        if (e.len > 1) u_fq.push(b1, gap);
        if (e.len > 2) u_fq.push(b2, gap);
    endtask

    // One table form with random register, selector and operand bytes
    task automatic run_form(int k, int gap, bit memf);
        logic [31:0] r;
        logic [7:0]  o;
        logic [7:0]  m;
        r = rnd();
        o = forms[k];
        m = r[15:8];
        if (o == 8'h50 || o == 8'h58 || o == 8'h90) o[2:0] = r[2:0];
        if (o == 8'h06 || o == 8'h07) o[4:3] = r[4:3];
        m[7:6] = memf ? ((r[15:14] == 2'b11) ? 2'b10 : r[15:14]) : 2'b11;
        if (o == 8'hFF) m[5:3] = 3'b110;
        if (o == 8'h8F) m[5:3] = 3'b000;
        if (o == 8'h8C) m[5] = 1'b0;
        send(o, m, r[23:16], gap);
    endtask

    task automatic drain(string name);
        int n;
        n = 0;
        while (exp_q.size() != 0 && n < 5000) begin
            @(posedge core_clk_i);
            n++;
        end
        if (n >= 5000) n_mismatch++;
        // With the queue empty the decoder must settle back to idle
        repeat (2) @(posedge core_clk_i);
        chk("idle busy", {15'h0000, busy_o}, 16'h0000);
        $display("Test %s ended: %0d checks, %0d mismatches", name, tests_run, n_mismatch);
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Completion check; the echo of the last take lands one edge late, so the count is the echo distance plus one
    always @(posedge core_clk_i) begin
        sxpd_exp_type e;
        since_take <= (q_take_o === 1'b1) ? 0 : since_take + 1;
        if (done_o === 1'b1) begin
            if (exp_q.size() == 0) begin
                chk("unexpected done", 16'h0001, 16'h0000);
            end else begin
                e = exp_q.pop_front();
                chk("op", {12'h000, op_o}, {12'h000, e.op});
                chk("cycles", {10'h000, cycles_o}, {10'h000, e.cyc});
                chk("latency", since_take[15:0] + 16'h0001, {10'h000, e.cyc});
                chk("busy", {15'h0000, busy_o}, 16'h0001);
                if (e.cf) chk("width", {15'h0000, word_o}, {15'h0000, e.w});
                if (e.cf) chk("reg", {13'h0000, reg_o}, {13'h0000, e.r});
                if (e.ci) chk("imm", imm_o, e.imm);
                if (e.cm) chk("modrm", {8'h00, modrm_o}, {8'h00, e.m});
            end
        end
    end

    // Hang guard, well above the few thousand cycles the run needs
    always @(posedge core_clk_i) begin
        cyc_cnt <= cyc_cnt + 1;
        if (cyc_cnt == 20000) begin
            n_mismatch++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        reset_i = 1'b1;
        repeat (10) @(posedge core_clk_i);
        reset_i <= 1'b0;
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 16; k++) run_form(k, 0, p[0]);
            drain("all forms");
        end
        // Undecoded forms, and the one legal neighbour of the excluded selector
        send(8'hFF, 8'hC0, 8'h00, 0);
        send(8'h8F, 8'h30, 8'h00, 0);
        send(8'h0F, 8'h00, 8'h00, 0);
        send(8'h17, 8'h00, 8'h00, 0);
        send(8'h69, 8'h00, 8'h00, 0);
        drain("undecoded");
        // Back to back first, then a source that stalls at random
        for (int i = 0; i < 60; i++) run_form(int'(rnd() % 32'd16), (i < 30) ? 0 : int'(rnd() % 32'd4), i[0]);
        drain("streams");
        print_verdict();
    end
endmodule
